//--- hw/uefa_top.sv
/*
 Firmware access path to the USB endpoint FIFOs: data window, byte counts,
 per-endpoint flush bits and the endpoint selector.
 Assumes a single-cycle register bus on clk; reads are answered one cycle later.
*/
// Contract
// - Eight-bit data window writes into or reads from the selected endpoint FIFO.
// - Data and both counts follow the endpoint chosen in the selector register.
// - Low count register shows count bits seven to zero of last packet.
// - High count register holds upper count bits low; other bits read zero.
// - Flush bit n resets endpoint n FIFO; bit seven reserved reads zero.
`timescale 1ns/1ps
module uefa_top import uefa_pkg::*; (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register bus
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  // Packet engine
  input  wire logic [UEFA_EP_W-1:0] pk_ep,
  input  wire logic                 pk_wr,
  input  wire logic [7:0]           pk_wdata,
  input  wire logic                 pk_done,
  // Status toward the rest of the module
  output logic [UEFA_EP_W-1:0]      selected_endpoint_index,
  output logic [UEFA_NUM_EP-1:0]    flush_active
);
  ////////////////////////////////////////////////////////////////////////
  logic [UEFA_EP_W-1:0]  sel_ff;
  logic [7:0]            flush_ff;
  logic [7:0]            rdata_ff;
  logic [7:0]            ep_rdata [UEFA_NUM_EP];
  logic [UEFA_CNT_W-1:0] ep_count [UEFA_NUM_EP];
  logic [UEFA_PTR_W-1:0] ep_ptr   [UEFA_NUM_EP];

  wire hit_sel   = reg_addr == UEFA_OFS_SELECT;
  wire hit_data  = reg_addr == UEFA_OFS_DATA;
  wire hit_flush = reg_addr == UEFA_OFS_FLUSH;
  wire hit_lo    = reg_addr == UEFA_OFS_CNT_LOW;
  wire hit_hi    = reg_addr == UEFA_OFS_CNT_HIGH;
  // Out-of-range selector picks no endpoint; data and count reads then return zero
  wire sel_ok    = sel_ff < UEFA_EP_W'(UEFA_NUM_EP);

  wire [UEFA_CNT_W-1:0] sel_count = sel_ok ? ep_count[sel_ff] : 11'h000;
  wire [7:0] sel_byte  = sel_ok ? ep_rdata[sel_ff] : 8'h00;
  wire [7:0] cnt_low   = sel_count[7:0];
  wire [7:0] cnt_high  = {5'h00, sel_count[UEFA_CNT_W-1:8]};

  wire [7:0] nxt_rdata =
    hit_sel   ? {5'h00, sel_ff} :
    hit_data  ? sel_byte :
    hit_flush ? flush_ff :
    hit_lo    ? cnt_low :
    hit_hi    ? cnt_high : 8'h00;

  // Register strobes, decoded once
  wire hit_none = !(hit_sel || hit_data || hit_flush || hit_lo || hit_hi);
  wire wr_sel   = reg_wr && hit_sel;
  wire wr_flush = reg_wr && hit_flush;
  wire wr_data  = reg_wr && hit_data;
  wire rd_data  = reg_rd && hit_data;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_ff <= UEFA_SELECT_RESET;
    end else if (wr_sel) begin
      sel_ff <= reg_wdata[UEFA_EP_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flush_ff <= UEFA_FLUSH_RESET;
    end else if (wr_flush) begin
      flush_ff <= reg_wdata & UEFA_FLUSH_MASK;
    end
  end

  // Read data moves only on a read, so a slow poll sees a stable byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata               = rdata_ff;
  assign selected_endpoint_index = sel_ff;
  assign flush_active            = flush_ff[UEFA_NUM_EP-1:0];

  ////////////////////////////////////////////////////////////////////////
  // Firmware must drain before clearing the received flag
  // packet engine refuses new OUT data meanwhile; on overlap the FIFO lets a firmware write win the memory.
  for (genvar i = 0; i < UEFA_NUM_EP; i++) begin : g_ep
    wire is_sel    = sel_ok && (sel_ff == UEFA_EP_W'(i));
    wire fw_wr_i   = wr_data && is_sel;
    wire fw_rd_i   = rd_data && is_sel;
    // A flushing endpoint drops engine traffic instead of queueing it
    wire pk_hit_i  = pk_ep == UEFA_EP_W'(i) && !flush_ff[i];
    wire pk_wr_i   = pk_wr && pk_hit_i;
    wire pk_done_i = pk_done && pk_hit_i;

    uefa_ep_fifo #(
      .DEPTH((i == 6) ? 512 : (i >= 4) ? 64 : 32)
    ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .flush    (flush_ff[i]),
      .fw_wr    (fw_wr_i),
      .fw_rd    (fw_rd_i),
      .fw_wdata (reg_wdata),
      .fw_rdata (ep_rdata[i]),
      .pk_wr    (pk_wr_i),
      .pk_wdata (pk_wdata),
      .pk_done  (pk_done_i),
      .rx_count (ep_count[i]),
      .ptr      (ep_ptr[i])
    );

    ptr_step_a: assert property (@(posedge clk) disable iff (rst)
      (fw_wr_i || fw_rd_i) && !flush_ff[i] |=> ep_ptr[i] == $past(ep_ptr[i]) + 10'h001)
      else $error("pointer did not advance");

    ptr_idle_a: assert property (@(posedge clk) disable iff (rst)
      !is_sel && !flush_ff[i] |=> $stable(ep_ptr[i]))
      else $error("unselected pointer moved");

    ep_flush_a: assert property (@(posedge clk) disable iff (rst)
      flush_ff[i] |=> ep_count[i] == 11'h000 && ep_ptr[i] == 10'h000)
      else $error("flush left endpoint state");

    count_hold_a: assert property (@(posedge clk) disable iff (rst)
      !pk_done_i && !flush_ff[i] |=> $stable(ep_count[i]))
      else $error("count changed without packet end");
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  rsv_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_flush |=> !reg_rdata[7])
    else $error("reserved flush bit reads one");

  hi_zero_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_hi |=> reg_rdata[7:3] == 5'h00)
    else $error("high count upper bits");

  hi_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_hi |=> reg_rdata == $past(cnt_high))
    else $error("high count mismatch");

  lo_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_lo |=> reg_rdata == $past(cnt_low))
    else $error("low count mismatch");

  data_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_data |=> reg_rdata == $past(sel_byte))
    else $error("data window read");

  sel_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_sel |=> reg_rdata == {5'h00, $past(sel_ff)})
    else $error("selector readback");

  nosel_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && (hit_data || hit_lo || hit_hi) && !sel_ok |=> reg_rdata == 8'h00)
    else $error("empty selector read nonzero");

  unmapped_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && hit_none |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");

  rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // Selector and flush registers
  sel_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_sel |=> sel_ff == $past(reg_wdata[2:0]))
    else $error("selector update");

  sel_hold_a: assert property (@(posedge clk) disable iff (rst)
    !wr_sel |=> $stable(sel_ff))
    else $error("selector moved without a write");

  flush_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_flush |=> flush_ff == ($past(reg_wdata) & UEFA_FLUSH_MASK))
    else $error("flush");

  flush_hold_a: assert property (@(posedge clk) disable iff (rst)
    !wr_flush |=> $stable(flush_ff))
    else $error("flush bits moved without a write");

  flush_cnt_a: assert property (@(posedge clk) disable iff (rst)
    flush_ff[0] |=> ep_count[0] == 11'h000)
    else $error("flush keeps count");

  flush_out_a: assert property (@(posedge clk) disable iff (rst)
    wr_flush |=> flush_active == $past(reg_wdata[6:0]))
    else $error("flush output");

  reset_a: assert property (@(posedge clk)
    rst |=> reg_rdata == 8'h00 &&
            sel_ff == UEFA_SELECT_RESET &&
            flush_ff == UEFA_FLUSH_RESET)
    else $error("reset values");

  // Main scenarios
  cv_data_rd: cover property (@(posedge clk)
    rd_data ##1 rd_data);

  cv_flush: cover property (@(posedge clk)
    wr_flush && reg_wdata[6]);

  cv_pkt: cover property (@(posedge clk)
    pk_done ##1 reg_rd && hit_hi);

  cv_nosel: cover property (@(posedge clk)
    rd_data && !sel_ok);

  cv_big_pkt: cover property (@(posedge clk)
    pk_done && pk_ep == 3'h6);
endmodule

//--- hw/uefa_pkg.sv
/*
 Constants for the endpoint FIFO access block: register offsets on the
 special function register bus, field positions and sizes.
 Assumes a byte-wide register bus with an 8-bit address.
*/
package uefa_pkg;
  localparam logic [7:0] UEFA_OFS_SELECT    = 8'hc7;
  localparam logic [7:0] UEFA_OFS_DATA      = 8'hcf;
  localparam logic [7:0] UEFA_OFS_FLUSH     = 8'hd5;
  localparam logic [7:0] UEFA_OFS_CNT_LOW   = 8'he2;
  localparam logic [7:0] UEFA_OFS_CNT_HIGH  = 8'he3;
  localparam int         UEFA_NUM_EP        = 7;
  localparam int         UEFA_EP_W          = 3;
  localparam int         UEFA_CNT_W         = 11;
  localparam int         UEFA_PTR_W         = 10;
  localparam int         UEFA_CNT_HI_W      = 3;
  localparam logic [7:0] UEFA_FLUSH_RESET   = 8'h00;
  localparam logic [2:0] UEFA_SELECT_RESET  = 3'h0;
  localparam logic [7:0] UEFA_FLUSH_MASK    = 8'h7f;
endpackage

//--- hw/uefa_ep_fifo.sv
/*
 One endpoint FIFO: byte storage, a pointer shared by firmware access,
 and the received byte count reported by the packet engine.
 Assumes the packet engine writes bytes and latches the count on packet end.
*/
`timescale 1ns/1ps
module uefa_ep_fifo import uefa_pkg::*; #(
  parameter int DEPTH = 64
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Firmware side
  input  wire logic                  flush,
  input  wire logic                  fw_wr,
  input  wire logic                  fw_rd,
  input  wire logic [7:0]            fw_wdata,
  output logic      [7:0]            fw_rdata,
  // Packet engine side
  input  wire logic                  pk_wr,
  input  wire logic [7:0]            pk_wdata,
  input  wire logic                  pk_done,
  output logic      [UEFA_CNT_W-1:0] rx_count,
  output logic      [UEFA_PTR_W-1:0] ptr
);
  logic [7:0]            mem [DEPTH];
  logic [UEFA_PTR_W-1:0] ptr_ff;
  logic [UEFA_PTR_W-1:0] wptr_ff;
  logic [UEFA_CNT_W-1:0] cnt_ff;
  wire  [UEFA_PTR_W-1:0] nxt_ptr  = ptr_ff + 10'h001;
  wire  [UEFA_PTR_W-1:0] nxt_wptr = wptr_ff + 10'h001;
  wire                   fw_step  = fw_wr | fw_rd;
  // Depth must be a power of two within the pointer range
  localparam int AW = $clog2(DEPTH);
  wire  [AW-1:0]         rd_idx   = ptr_ff[AW-1:0];
  wire  [AW-1:0]         wr_idx   = wptr_ff[AW-1:0];

  assign fw_rdata = mem[rd_idx];
  assign rx_count = cnt_ff;
  assign ptr      = ptr_ff;

  always_ff @(posedge clk) begin
    if (fw_wr) begin
      mem[rd_idx] <= fw_wdata;
    end else if (pk_wr) begin
      mem[wr_idx] <= pk_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      ptr_ff  <= 10'h000;
      wptr_ff <= 10'h000;
      cnt_ff  <= 11'h000;
    end else begin
      if (fw_step) begin
        ptr_ff <= nxt_ptr;
      end
      if (pk_wr) begin
        wptr_ff <= nxt_wptr;
      end
      if (pk_done) begin
        cnt_ff  <= {1'b0, wptr_ff};
        wptr_ff <= 10'h000;
      end
    end
  end
endmodule

//--- test/uefa_host_model.sv
/* Host-side packet source: len bytes counting up from base, then packet end.
   Assumes go is pulsed only while busy is low. */
`timescale 1ns/1ps
module uefa_host_model (
  // Clock, reset and request
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [2:0] ep,
  input  wire logic [9:0] len,
  input  wire logic [7:0] base,
  // Packet engine side
  output logic      [2:0] pk_ep,
  output logic            pk_wr,
  output logic      [7:0] pk_wdata,
  output logic            pk_done,
  output logic            busy
);
  logic [9:0] n_ff;
  always_ff @(posedge clk) begin
    pk_wr <= 1'b0;
    pk_done <= 1'b0;
    // Idle byte toggles so a stale value is never trusted
    pk_wdata <= ~pk_wdata;
    if (rst) begin
      busy <= 1'b0;
      pk_ep <= 3'h0;
      pk_wdata <= 8'h00;
    end else if (go) begin
      busy <= 1'b1;
      n_ff <= 10'h000;
      pk_ep <= ep;
    end else if (busy && n_ff != len) begin
      pk_wr <= 1'b1;
      pk_wdata <= base + n_ff[7:0];
      n_ff <= n_ff + 10'h001;
    end else if (busy) begin
      pk_done <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

//--- test/tb.sv
/* Self-checking bench for the endpoint FIFO access block.
   Assumes the host model feeds the packet engine inputs. */
`timescale 1ns/1ps
module tb;
  import uefa_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, busy, pw, pd;
  logic [7:0] a = 0, wd = 0, q, pdat, base = 0;
  logic [2:0] hep = 0, pep, sel;
  logic [9:0] len = 0;
  logic [6:0] fl;
  logic [7:0] mem_m [7][512];
  int cnt_m [7];
  int bad_count = 0, samples_checked = 0, seed = 32'h3abe, k, e;
  always #4 clk = ~clk;
  uefa_top u_dut (.clk(clk), .rst(rst), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wd), .reg_rdata(q), .pk_ep(pep), .pk_wr(pw), .pk_wdata(pdat), .pk_done(pd),
    .selected_endpoint_index(sel), .flush_active(fl));
  uefa_host_model u_host (.clk(clk), .rst(rst), .go(go), .ep(hep), .len(len), .base(base),
    .pk_ep(pep), .pk_wr(pw), .pk_wdata(pdat), .pk_done(pd), .busy(busy));
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, x);
    samples_checked++;
    if (s !== x) begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic wt(input logic [7:0] ad, d);
    @(posedge clk);
    #1 {a, wd, wr} = {ad, d, 1'b1};
    @(posedge clk);
    #1 wr = 0;
  endtask
  task automatic rc(input logic [7:0] ad, x);
    @(posedge clk);
    #1 {a, rd} = {ad, 1'b1};
    @(posedge clk);
    #1 rd = 0;
    chk(q, x);
  endtask
  task automatic send(input int ep, n);
    base = $random(seed);
    for (k = 0; k < n; k++) mem_m[ep][k] = base + k[7:0];
    cnt_m[ep] = n;
    @(posedge clk);
    #1 {hep, len, go} = {ep[2:0], n[9:0], 1'b1};
    @(posedge clk);
    #1 go = 0;
    for (k = 0; k < 999 && busy; k++) @(posedge clk);
    if (busy) begin
      bad_count++;
      conclude();
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    rc(UEFA_OFS_FLUSH, 8'h00);
    rc(UEFA_OFS_SELECT, 8'h00);
    for (e = 0; e < 7; e++) begin
      send(e, e == 6 ? 300 : (e > 3 ? 64 : 32));
      wt(UEFA_OFS_SELECT, e[7:0]);
      chk({5'h0, sel}, e[7:0]);
      rc(UEFA_OFS_CNT_LOW, cnt_m[e][7:0]);
      rc(UEFA_OFS_CNT_HIGH, {5'h0, cnt_m[e][10:8]});
      // Whole packet drained before any received flag could be cleared
      for (k = 0; k < cnt_m[e]; k++) begin
        rc(UEFA_OFS_DATA, mem_m[e][k]);
      end
      $display("endpoint %0d test done", e);
    end
    wt(UEFA_OFS_FLUSH, 8'hff);
    rc(UEFA_OFS_FLUSH, 8'h7f);
    chk({1'b0, fl}, 8'h7f);
    wt(UEFA_OFS_FLUSH, 8'h00);
    wt(UEFA_OFS_SELECT, 8'h02);
    rc(UEFA_OFS_CNT_LOW, 8'h00);
    send(2, 3);
    mem_m[2][0] = base ^ 8'h80;
    wt(UEFA_OFS_DATA, mem_m[2][0]);
    rc(UEFA_OFS_DATA, mem_m[2][1]);
    // Flush rewinds the pointer and count but keeps the stored bytes
    wt(UEFA_OFS_FLUSH, 8'h04);
    wt(UEFA_OFS_FLUSH, 8'h00);
    rc(UEFA_OFS_CNT_LOW, 8'h00);
    rc(UEFA_OFS_DATA, mem_m[2][0]);
    $display("flush test done");
    wt(UEFA_OFS_SELECT, 8'h07);
    rc(UEFA_OFS_DATA, 8'h00);
    rc(UEFA_OFS_CNT_LOW, 8'h00);
    rc(8'h10, 8'h00);
    $display("refusal test done");
    wt(UEFA_OFS_FLUSH, 8'h41);
    @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    rc(UEFA_OFS_SELECT, 8'h00);
    chk({1'b0, fl}, 8'h00);
    $display("reset test done");
    conclude();
  end
endmodule
